// ### hw/isdbr_pkg.sv
// Package for the startup-handling configuration bank: offsets, fields,
// reset values and the decode scales.
// Assumes a 100 MHz core clock and a simple word-wide register port.
package isdbr_pkg;

  // Register offsets.
  localparam logic [7:0] ISD_SETTINGS_OFFSET = 8'h80;
  localparam logic [7:0] REV_SETTINGS_OFFSET = 8'h82;

  // Reset values.
  localparam logic [31:0] ISD_SETTINGS_RESET = 32'h00000000;
  localparam logic [31:0] REV_SETTINGS_RESET = 32'h00000000;

  // Field positions, initial speed detect register.
  localparam int RESYNC_LSB   = 22;
  localparam int FET_SEL_BIT  = 21;
  localparam int EXIT_SEL_BIT = 20;
  localparam int BCUR_LSB     = 17;
  localparam int BDUR_LSB     = 13;
  localparam int COAST_LSB    = 9;
  localparam int STAT_LSB     = 6;
  localparam int HAND_LSB     = 2;
  localparam int RCUR_LSB     = 0;

  // Field positions, reverse drive register.
  localparam int ACC1_LSB = 27;
  localparam int ACC2_LSB = 23;
  localparam int ABCL_LSB = 20;
  localparam int KP_LSB   = 10;
  localparam int KI_LSB   = 0;

  // Gain fraction widths.
  localparam int KP_FRAC = 7;
  localparam int KI_FRAC = 9;

  // Active braking current code that is reserved.
  localparam logic [2:0] ABCL_RESERVED = 3'h7;

  // Clock rate and the duration scale in milliseconds.
  localparam int CLK_HZ = 100_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;

  // Brake state sequence.
  typedef enum logic [1:0] {ST_IDLE, ST_COAST, ST_BRAKE, ST_DONE}
    isdbr_state_type;

endpackage : isdbr_pkg

// ### hw/isdbr_timer.sv
// Millisecond-based countdown timer for the coast and brake phases.
// Assumes a start pulse with the length in milliseconds already decoded.
`timescale 1ns/1ps
module isdbr_timer (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        start_i,
  input  wire logic [14:0] ms_i,
  output logic             done_o
);
  import isdbr_pkg::*;

  typedef struct packed {
    logic [16:0] pre;
    logic [14:0] ms;
    logic        run;
    logic        done;
  } isdbr_tmr_type;

  isdbr_tmr_type s;
  isdbr_tmr_type next_s;

  // Prescale to milliseconds, then count down the milliseconds.
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start_i) begin
      next_s.run = 1'b1;
      next_s.ms  = ms_i;
      next_s.pre = 17'(CYC_PER_MS - 1);
    end else if (s.run) begin
      if (s.pre != 17'h00000) begin
        next_s.pre = s.pre - 17'h00001;
      end else if (s.ms <= 15'h0001) begin
        next_s.run  = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.ms  = s.ms - 15'h0001;
        next_s.pre = 17'(CYC_PER_MS - 1);
      end
    end
  end

  // State register.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done_o = s.done;

endmodule : isdbr_timer

// ### hw/isdbr_bank.sv
// Startup-handling configuration bank with brake and coast sequencer.
// Assumes a synchronous word-wide register port on the core clock.
`timescale 1ns/1ps
module isdbr_bank (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        start_i,
  input  wire logic        brake_en_i,
  input  wire logic        coast_en_i,
  input  wire logic [15:0] bemf_mv_i,
  input  wire logic [15:0] phase_ma_i,
  output logic [31:0]      rdata_o,
  output logic             rvalid_o,
  output logic [2:0]       hs_on_o,
  output logic [2:0]       ls_on_o,
  output logic             hiz_o,
  output logic             stationary_o,
  output logic             seq_done_o,
  output logic [15:0]      brake_ma_o,
  output logic [7:0]       handoff_pct_x2_o,
  output logic [15:0]      rev_ol_ma_o,
  output logic [23:0]      accel1_centi_o,
  output logic [15:0]      ab_limit_ma_o,
  output logic             ab_limit_bad_o,
  output logic [16:0]      kp_q7_o,
  output logic [18:0]      ki_q9_o
);
  import isdbr_pkg::*;

  // Duration scale, shared by brake and coast time codes.
  function automatic logic [14:0] dur_ms(input logic [3:0] c);
    unique case (c)
      4'h0: dur_ms = 15'd10;    4'h1: dur_ms = 15'd50;
      4'h2: dur_ms = 15'd100;   4'h3: dur_ms = 15'd200;
      4'h4: dur_ms = 15'd300;   4'h5: dur_ms = 15'd400;
      4'h6: dur_ms = 15'd500;   4'h7: dur_ms = 15'd750;
      4'h8: dur_ms = 15'd1000;  4'h9: dur_ms = 15'd2000;
      4'hA: dur_ms = 15'd3000;  4'hB: dur_ms = 15'd4000;
      4'hC: dur_ms = 15'd5000;  4'hD: dur_ms = 15'd7500;
      4'hE: dur_ms = 15'd10000; 4'hF: dur_ms = 15'd15000;
    endcase
  endfunction : dur_ms

  // Brake current threshold in mA times 10 would lose nothing; use 0.1 mA.
  function automatic logic [15:0] bcur(input logic [2:0] c);
    unique case (c)
      3'h0: bcur = 16'd625;   3'h1: bcur = 16'd1250;
      3'h2: bcur = 16'd1875;  3'h3: bcur = 16'd3125;
      3'h4: bcur = 16'd6250;  3'h5: bcur = 16'd12500;
      3'h6: bcur = 16'd25000; 3'h7: bcur = 16'd50000;
    endcase
  endfunction : bcur

  function automatic logic [15:0] stat_mv(input logic [2:0] c);
    unique case (c)
      3'h0: stat_mv = 16'd50;   3'h1: stat_mv = 16'd75;
      3'h2: stat_mv = 16'd100;  3'h3: stat_mv = 16'd250;
      3'h4: stat_mv = 16'd500;  3'h5: stat_mv = 16'd750;
      3'h6: stat_mv = 16'd1000; 3'h7: stat_mv = 16'd1500;
    endcase
  endfunction : stat_mv

  // Handoff speed in half-percent steps.
  function automatic logic [7:0] hand(input logic [3:0] c);
    unique case (c)
      4'h0: hand = 8'd5;   4'h1: hand = 8'd10;  4'h2: hand = 8'd15;
      4'h3: hand = 8'd20;  4'h4: hand = 8'd25;  4'h5: hand = 8'd30;
      4'h6: hand = 8'd40;  4'h7: hand = 8'd50;  4'h8: hand = 8'd60;
      4'h9: hand = 8'd80;  4'hA: hand = 8'd100; 4'hB: hand = 8'd120;
      4'hC: hand = 8'd140; 4'hD: hand = 8'd160; 4'hE: hand = 8'd180;
      4'hF: hand = 8'd200;
    endcase
  endfunction : hand

  // Reversal open-loop current in 0.1 mA.
  function automatic logic [15:0] rcur(input logic [1:0] c);
    unique case (c)
      2'h0: rcur = 16'd9375;  2'h1: rcur = 16'd15625;
      2'h2: rcur = 16'd21875; 2'h3: rcur = 16'd31250;
    endcase
  endfunction : rcur

  // Acceleration A1 in 0.01 Hz/s; code E is unprinted and repeats D.
  function automatic logic [23:0] acc1(input logic [3:0] c);
    unique case (c)
      4'h0: acc1 = 24'd1;      4'h1: acc1 = 24'd5;
      4'h2: acc1 = 24'd100;    4'h3: acc1 = 24'd250;
      4'h4: acc1 = 24'd500;    4'h5: acc1 = 24'd1000;
      4'h6: acc1 = 24'd2500;   4'h7: acc1 = 24'd5000;
      4'h8: acc1 = 24'd7500;   4'h9: acc1 = 24'd10000;
      4'hA: acc1 = 24'd25000;  4'hB: acc1 = 24'd50000;
      4'hC: acc1 = 24'd75000;  4'hD: acc1 = 24'd100000;
      4'hE: acc1 = 24'd100000; 4'hF: acc1 = 24'd1000000;
    endcase
  endfunction : acc1

  // Active braking limit in mA; the reserved code yields zero.
  function automatic logic [15:0] abcl(input logic [2:0] c);
    unique case (c)
      3'h0: abcl = 16'd312;  3'h1: abcl = 16'd625;
      3'h2: abcl = 16'd1250; 3'h3: abcl = 16'd1875;
      3'h4: abcl = 16'd2500; 3'h5: abcl = 16'd3125;
      3'h6: abcl = 16'd3750; 3'h7: abcl = 16'd0;
    endcase
  endfunction : abcl

  typedef struct packed {
    logic [31:0]     isd;
    logic [31:0]     rev;
    logic [31:0]     rdata;
    logic            rvalid;
    isdbr_state_type st;
    logic [2:0]      hs;
    logic [2:0]      ls;
    logic            hiz;
    logic            stat;
    logic            done;
    logic            tstart;
    logic [14:0]     tms;
    logic [15:0]     bma;
    logic [7:0]      hpct;
    logic [15:0]     rma;
    logic [23:0]     a1;
    logic [15:0]     ab;
    logic            abbad;
    logic [16:0]     kp;
    logic [18:0]     ki;
  } isdbr_bank_type;

  isdbr_bank_type s;
  isdbr_bank_type next_s;
  logic           tdone;
  logic           cur_low;

  isdbr_timer u_timer (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .start_i  (s.tstart),
    .ms_i     (s.tms),
    .done_o   (tdone)
  );

  // Phase current in 0.1 mA compared to the brake exit threshold.
  assign cur_low = ({phase_ma_i, 4'h0} - {phase_ma_i, 2'h0} - phase_ma_i
                    - phase_ma_i) < {4'h0, bcur(s.isd[BCUR_LSB +: 3])};

  // Register access, decoders and the coast and brake sequence.
  always_comb begin
    next_s = s;
    next_s.tstart = 1'b0;
    next_s.done   = 1'b0;
    next_s.rvalid = rd_en_i;
    if (wr_en_i && addr_i == ISD_SETTINGS_OFFSET) begin
      next_s.isd = wdata_i;
    end
    if (wr_en_i && addr_i == REV_SETTINGS_OFFSET) begin
      next_s.rev = wdata_i;
    end
    if (rd_en_i) begin
      unique case (addr_i)
        ISD_SETTINGS_OFFSET: next_s.rdata = s.isd;
        REV_SETTINGS_OFFSET: next_s.rdata = s.rev;
        default:             next_s.rdata = 32'h00000000;
      endcase
    end
    next_s.stat = {16'h0000, bemf_mv_i} <
                  {16'h0000, stat_mv(s.isd[STAT_LSB +: 3])};
    next_s.bma  = bcur(s.isd[BCUR_LSB +: 3]);
    next_s.hpct = hand(s.isd[HAND_LSB +: 4]);
    next_s.rma  = rcur(s.isd[RCUR_LSB +: 2]);
    next_s.a1   = acc1(s.rev[ACC1_LSB +: 4]);
    next_s.ab   = abcl(s.rev[ABCL_LSB +: 3]);
    next_s.abbad = s.rev[ABCL_LSB +: 3] == ABCL_RESERVED;
    next_s.kp   = {s.rev[KP_LSB +: 10], 7'h00};
    next_s.ki   = {s.rev[KI_LSB +: 10], 9'h000};
    unique case (s.st)
      ST_IDLE: begin
        if (start_i && coast_en_i) begin
          next_s.st  = ST_COAST;
          next_s.hiz = 1'b1;
          next_s.tstart = 1'b1;
          next_s.tms = dur_ms(s.isd[COAST_LSB +: 4]);
        end else if (start_i && brake_en_i) begin
          next_s.st  = ST_BRAKE;
          next_s.tstart = 1'b1;
          next_s.tms = dur_ms(s.isd[BDUR_LSB +: 4]);
        end else if (start_i) begin
          next_s.st = ST_DONE;
        end
      end
      ST_COAST: begin
        if (tdone) begin
          next_s.hiz = 1'b0;
          if (brake_en_i) begin
            next_s.st = ST_BRAKE;
            next_s.tstart = 1'b1;
            next_s.tms = dur_ms(s.isd[BDUR_LSB +: 4]);
          end else begin
            next_s.st = ST_DONE;
          end
        end
      end
      ST_BRAKE: begin
        next_s.hs = s.isd[FET_SEL_BIT] ? 3'h0 : 3'h7;
        next_s.ls = s.isd[FET_SEL_BIT] ? 3'h7 : 3'h0;
        if (tdone && (!s.isd[EXIT_SEL_BIT] || cur_low)) begin
          next_s.st = ST_DONE;
          next_s.hs = 3'h0;
          next_s.ls = 3'h0;
        end else if (tdone) begin
          next_s.tstart = 1'b1;
          next_s.tms = 15'd1;
        end
      end
      ST_DONE: begin
        next_s.done = 1'b1;
        next_s.st = ST_IDLE;
      end
    endcase
  end

  // State register; both registers clear to zero.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s     <= '0;
      s.isd <= ISD_SETTINGS_RESET;
      s.rev <= REV_SETTINGS_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o          = s.rdata;
  assign rvalid_o         = s.rvalid;
  assign hs_on_o          = s.hs;
  assign ls_on_o          = s.ls;
  assign hiz_o            = s.hiz;
  assign stationary_o     = s.stat;
  assign seq_done_o       = s.done;
  assign brake_ma_o       = s.bma;
  assign handoff_pct_x2_o = s.hpct;
  assign rev_ol_ma_o      = s.rma;
  assign accel1_centi_o   = s.a1;
  assign ab_limit_ma_o    = s.ab;
  assign ab_limit_bad_o   = s.abbad;
  assign kp_q7_o          = s.kp;
  assign ki_q9_o          = s.ki;

  // Checks on the register port, the brake and coast outputs, the stationary flag and the decoders.
  a_rev_readback: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    wr_en_i && addr_i == REV_SETTINGS_OFFSET ##1 rd_en_i && !wr_en_i
      && addr_i == REV_SETTINGS_OFFSET |=> rdata_o == $past(wdata_i, 2))
    else $error("Reverse register readback mismatch.");
  a_fet_high: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    s.st == ST_BRAKE && hs_on_o != 3'h0 |-> !$past(s.isd[FET_SEL_BIT]))
    else $error("High sides on with low side selected.");
  a_fet_low: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ls_on_o != 3'h0 |-> $past(s.isd[FET_SEL_BIT]) && hs_on_o == 3'h0)
    else $error("Low sides on wrongly.");
  a_brake_exit: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    s.st == ST_BRAKE && tdone && !s.isd[EXIT_SEL_BIT] |=> s.st == ST_DONE)
    else $error("Brake did not end on time.");
  a_coast_hiz: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    s.st == ST_COAST |-> hiz_o)
    else $error("Outputs not high impedance in coast.");
  a_stat_detect: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ##1 stationary_o == ($past(bemf_mv_i) <
      stat_mv($past(s.isd[STAT_LSB +: 3]))))
    else $error("Stationary flag wrong.");
  a_kp_scale: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ##1 kp_q7_o[16:7] == $past(s.rev[KP_LSB +: 10]) && kp_q7_o[6:0] == 7'h00)
    else $error("Gain scaling wrong.");
  a_ab_reserved: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ##1 ab_limit_bad_o == ($past(s.rev[ABCL_LSB +: 3]) == ABCL_RESERVED))
    else $error("Reserved limit flag wrong.");
  c_coast: cover property (@(posedge clock_i) s.st == ST_COAST);
  c_brake_low: cover property (@(posedge clock_i) ls_on_o == 3'h7);
  c_done: cover property (@(posedge clock_i) seq_done_o);

endmodule : isdbr_bank

// ### tb/isdbr_host_model.sv
// Register-port master standing in for the external controller.
// Assumes tasks are called at any time; requests start after a rising edge.
`timescale 1ns/1ps
module isdbr_host_model (
  input  wire logic        clock_i,
  input  wire logic        rvalid_i,
  input  wire logic [31:0] rdata_i,
  output logic             wr_en_o,
  output logic             rd_en_o,
  output logic [7:0]       addr_o,
  output logic [31:0]      wdata_o
);
  // Idle bus at time zero.
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 32'h0;
  end

  // One write; released address and data show their inverse afterwards.
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    #1;
    wr_en_o = 1'b1;
    addr_o  = a;
    wdata_o = d;
    @(posedge clock_i);
    #1;
    wr_en_o = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : write_reg

  // One read; the answer is awaited for a bounded number of cycles.
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
                          output logic ok);
    @(posedge clock_i);
    #1;
    rd_en_o = 1'b1;
    addr_o  = a;
    ok      = 1'b0;
    d       = 32'hX;
    @(posedge clock_i);
    #1;
    rd_en_o = 1'b0;
    addr_o  = ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rvalid_i === 1'b1) begin
        ok = 1'b1;
        d  = rdata_i;
      end else begin
        @(posedge clock_i);
        #1;
      end
    end
  endtask : read_reg

  // Write, then read the same offset at the very next edge with no gap.
  task automatic write_read(input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q, output logic ok);
    @(posedge clock_i);
    #1;
    wr_en_o = 1'b1;
    addr_o  = a;
    wdata_o = d;
    ok      = 1'b0;
    q       = 32'hX;
    @(posedge clock_i);
    #1;
    wr_en_o = 1'b0;
    rd_en_o = 1'b1;
    wdata_o = ~d;
    @(posedge clock_i);
    #1;
    rd_en_o = 1'b0;
    addr_o  = ~a;
    if (rvalid_i === 1'b1) begin
      ok = 1'b1;
      q  = rdata_i;
    end
  endtask : write_read
endmodule : isdbr_host_model

// ### tb/tb_isd_brake_reverse_config.sv
// Self-checking bench for the startup-handling configuration bank.
// Assumes the host model drives the register port; 100 MHz clock.
`timescale 1ns/1ps
module tb_isd_brake_reverse_config;
  import isdbr_pkg::*;
  logic clock_i, arst_n_i, wr_en, rd_en, start, brake_en, coast_en, ok;
  logic rvalid, hiz, stat, sdone, ab_bad;
  logic [7:0]  addr, hand;
  logic [31:0] wdata, rdata, rd, seed, v;
  logic [15:0] bemf, phase, brake_ma, rev_ol, ab_lim;
  logic [2:0]  hs_on, ls_on;
  logic [23:0] acc1;
  logic [16:0] kp;
  logic [18:0] ki;
  int error_cnt, compares;
  localparam int BCUR[8] = '{625,1250,1875,3125,6250,12500,25000,50000};
  localparam int HAND[16] = '{5,10,15,20,25,30,40,50,60,80,100,120,140,
                              160,180,200};
  localparam int RCUR[4] = '{9375,15625,21875,31250};
  localparam int ACC[16] = '{1,5,100,250,500,1000,2500,5000,7500,10000,
                             25000,50000,75000,100000,100000,1000000};
  localparam int ABL[8] = '{312,625,1250,1875,2500,3125,3750,0};
  localparam int STAT[8] = '{50,75,100,250,500,750,1000,1500};

  isdbr_bank dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata),
    .start_i(start), .brake_en_i(brake_en), .coast_en_i(coast_en),
    .bemf_mv_i(bemf), .phase_ma_i(phase), .rdata_o(rdata),
    .rvalid_o(rvalid), .hs_on_o(hs_on), .ls_on_o(ls_on), .hiz_o(hiz),
    .stationary_o(stat), .seq_done_o(sdone), .brake_ma_o(brake_ma),
    .handoff_pct_x2_o(hand), .rev_ol_ma_o(rev_ol),
    .accel1_centi_o(acc1), .ab_limit_ma_o(ab_lim),
    .ab_limit_bad_o(ab_bad), .kp_q7_o(kp), .ki_q9_o(ki));
  isdbr_host_model host_u (.clock_i(clock_i), .rvalid_i(rvalid),
    .rdata_i(rdata), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
    .wdata_o(wdata));

  // Free-running 100 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Repeatable pseudo-random source.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Counts a compare and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  // Reset pulse that also aborts any running sequence.
  task automatic do_reset(input int n);
    @(posedge clock_i);
    #1;
    arst_n_i = 1'b0;
    start    = 1'b0;
    tick(n);
    arst_n_i = 1'b1;
  endtask : do_reset

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string m);
    host_u.read_reg(a, rd, ok);
    chk(32'(ok), 32'h1, "read answered");
    chk(rd, e, m);
  endtask : rd_chk

  // Starts a sequence and waits a bounded time for the phase to show.
  task automatic run_seq(input logic b, input logic c);
    brake_en = b;
    coast_en = c;
    start    = 1'b1;
    tick(1);
    start    = 1'b0;
    for (int i = 0; i < 4 && hiz !== 1'b1 && (hs_on | ls_on) == 3'h0; i++)
      tick(1);
  endtask : run_seq

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (30000) @(posedge clock_i);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end

  // Main sequence.
  initial begin
    error_cnt = 0;
    compares  = 0;
    seed      = 32'h000111DE;
    arst_n_i  = 1'b0;
    {start, brake_en, coast_en} = 3'h0;
    bemf  = 16'hFFFF;
    phase = 16'h0;
    tick(8);
    arst_n_i = 1'b1;
    rd_chk(REV_SETTINGS_OFFSET, 32'h0, "rev reset value");
    rd_chk(ISD_SETTINGS_OFFSET, 32'h0, "isd reset value");
    host_u.write_reg(8'h84, 32'hFFFFFFFF);
    rd_chk(8'h84, 32'h0, "unmapped read");
    rd_chk(REV_SETTINGS_OFFSET, 32'h0, "unmapped write ignored");
    $display("test reset_and_map done");
    for (int i = 0; i < 24; i++) begin
      v = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : xs();
      phase = v[31:16];
      host_u.write_reg(ISD_SETTINGS_OFFSET, v);
      tick(3);
      chk(32'(brake_ma), 32'(BCUR[v[19:17]]), "brake current");
      chk(32'(hand), 32'(HAND[v[5:2]]), "handoff speed");
      chk(32'(rev_ol), 32'(RCUR[v[1:0]]), "reversal current");
      rd_chk(ISD_SETTINGS_OFFSET, v, "isd readback");
      v = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : xs();
      host_u.write_reg(REV_SETTINGS_OFFSET, v);
      tick(3);
      chk(32'(acc1), 32'(ACC[v[30:27]]), "accel a1");
      chk(32'(ab_lim), 32'(ABL[v[22:20]]), "brake limit");
      chk(32'(ab_bad), 32'(v[22:20] == 3'h7), "reserved code");
      chk(32'(kp), {15'h0, v[19:10], 7'h0}, "kp");
      chk(32'(ki), {13'h0, v[9:0], 9'h0}, "ki");
      rd_chk(REV_SETTINGS_OFFSET, v, "rev readback");
    end
    v = xs();
    host_u.write_read(REV_SETTINGS_OFFSET, v, rd, ok);
    chk(32'(ok), 32'h1, "back to back answered");
    chk(rd, v, "back to back readback");
    $display("test decode done");
    for (int c = 0; c < 8; c++) begin
      host_u.write_reg(ISD_SETTINGS_OFFSET, 32'(c) << STAT_LSB);
      bemf = 16'(STAT[c] - 1);
      tick(3);
      chk(32'(stat), 32'h1, "below threshold");
      bemf = 16'(STAT[c]);
      tick(3);
      chk(32'(stat), 32'h0, "at threshold");
    end
    $display("test stationary done");
    host_u.write_reg(ISD_SETTINGS_OFFSET, 32'h3FFFFFFF);
    run_seq(1'b0, 1'b1);
    chk(32'(hiz), 32'h1, "coast hiz");
    chk(32'(hs_on | ls_on), 32'h0, "coast fets off");
    do_reset(2);
    rd_chk(ISD_SETTINGS_OFFSET, 32'h0, "reset mid-run");
    chk(32'(hiz), 32'h0, "hiz cleared by reset");
    for (int s = 0; s < 2; s++) begin
      host_u.write_reg(ISD_SETTINGS_OFFSET, 32'(s) << FET_SEL_BIT);
      run_seq(1'b1, 1'b0);
      chk(32'(hs_on), s ? 32'h0 : 32'h7, "brake high side");
      chk(32'(ls_on), s ? 32'h7 : 32'h0, "brake low side");
      do_reset(2);
    end
    {brake_en, coast_en} = 2'h0;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(1);
    chk(32'(sdone), 32'h1, "done pulse");
    tick(1);
    chk(32'(sdone), 32'h0, "done pulse ends");
    $display("test sequence done");
    wrap_up();
  end
endmodule : tb_isd_brake_reverse_config
